// ==== src/asu_uart.v ====
// Asynchronous serial channel: registers, baud generator, transmitter, receiver
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "asu_regs.vh"
module asu_uart
(
   // Clock and reset
   input wire core_clk_i,
   input wire srst_i,
   // Register port
   input wire [`ASU_ADDR_W-1:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   // Prescaled clock enables and external clock pin
   input wire [3:0] presc_tick_i,
   input wire ext_clock_pin_i,
   // Serial pins
   input wire rxd_i,
   output reg txd_o,
   output reg txd_oe_o,
   // Flow control pins and clock pin role
   input wire cts_n_i,
   input wire shared_port_pin_i,
   output reg rts_n_o,
   output reg rts_n_oe_o,
   output reg flow_pin_is_port_o,
   output reg clk_pin_is_port_o,
   // Requests
   output reg tx_irq_o,
   output reg rx_irq_o
);
localparam ST_IDLE = 2'h0;
localparam ST_START = 2'h1;
localparam ST_BITS = 2'h2;
reg [7:0] mode_reg;
reg [7:0] control0_reg;
reg [7:0] control1_reg;
reg [7:0] shared_serial_ctrl;
reg [7:0] baud_divider;
reg [8:0] tx_buffer;
reg [8:0] rx_buffer;
reg ovr_reg, frm_reg, par_reg, rx_full_reg, tx_be_reg, tx_empty_reg, started_reg;
reg ext_d_reg;
reg [7:0] div_cnt_reg;
reg [3:0] tx_sub_reg;
reg [3:0] rx_sub_reg;
reg [1:0] tx_st_reg;
reg [1:0] rx_st_reg;
reg [12:0] tx_sh_reg;
reg [3:0] tx_cnt_reg;
reg [12:0] rx_sh_reg;
reg [3:0] rx_cnt_reg;
reg [3:0] rx_len_reg;
reg rxs_d_reg;
wire [2:0] smd = mode_reg[`ASU_MODE_SMD_HI:`ASU_MODE_SMD_LO];
wire ena = (smd == `ASU_SMD_7BIT) || (smd == `ASU_SMD_8BIT) || (smd == `ASU_SMD_9BIT);
wire [3:0] clen = (smd == `ASU_SMD_7BIT) ? 4'h7 : (smd == `ASU_SMD_9BIT) ? 4'h9 : 4'h8;
wire msb = control0_reg[`ASU_C0_MSBFIRST] && (smd == `ASU_SMD_8BIT);
wire inv = control1_reg[`ASU_C1_LOGINV];
wire pol = mode_reg[`ASU_MODE_PIN_POLARITY_INVERT];
wire pen = mode_reg[`ASU_MODE_PEN];
wire podd = mode_reg[`ASU_MODE_PODD];
wire stop2 = mode_reg[`ASU_MODE_STOP2];
wire flow_on = !control0_reg[`ASU_C0_FLOWDIS];
wire cts_sel = flow_on && !control0_reg[`ASU_C0_FLOWDIR];
wire cts_in = shared_serial_ctrl[`ASU_SH_SPLIT] ? shared_port_pin_i : cts_n_i;
wire ext_sel = mode_reg[`ASU_MODE_CKSRC];
wire src_tick = ext_sel ? (ext_clock_pin_i && !ext_d_reg) :
   presc_tick_i[{control0_reg[`ASU_C0_PSC_HI], control0_reg[`ASU_C0_PSC_LO]}];
wire tick = ena && src_tick && (div_cnt_reg == 8'h00);
wire rx_pin = rxd_i ^ pol;
wire [3:0] tx_total = 4'h1 + clen + {3'h0, pen} + {3'h0, stop2} + 4'h1;
wire [8:0] tx_dat = tx_buffer ^ {9{inv}};
wire [8:0] tx_ord = msb ? {1'b0, tx_dat[0], tx_dat[1], tx_dat[2], tx_dat[3],
   tx_dat[4], tx_dat[5], tx_dat[6], tx_dat[7]} : tx_dat;
wire [8:0] tx_msk = tx_ord & ((9'h001 << clen) - 9'h001);
wire tx_par = (^tx_msk) ^ podd;
wire tx_go = tx_st_reg == ST_IDLE && control1_reg[`ASU_C1_TXON] && !tx_be_reg
   && !(cts_sel && cts_in);
wire rx_mid = tick && rx_sub_reg == `ASU_MID_TICK;
wire [12:0] rx_w = {rx_pin, rx_sh_reg[12:1]};
wire [12:0] rx_al = rx_w >> (4'hd - rx_len_reg);
wire [8:0] rx_raw = rx_al[8:0] & ((9'h001 << clen) - 9'h001);
wire rx_prb = (clen == 4'h7) ? rx_al[7] : (clen == 4'h8) ? rx_al[8] : rx_al[9];
wire [3:0] rx_s1i = clen + {3'h0, pen};
wire rx_s1 = rx_al[rx_s1i];
wire rx_s2 = stop2 ? rx_al[rx_s1i + 4'h1] : 1'b1;
wire [8:0] rx_ord = msb ? {1'b0, rx_raw[0], rx_raw[1], rx_raw[2], rx_raw[3],
   rx_raw[4], rx_raw[5], rx_raw[6], rx_raw[7]} : rx_raw;
wire rx_done = rx_st_reg == ST_BITS && rx_mid && rx_cnt_reg == 4'h1;
wire rx_prelast = rx_st_reg == ST_BITS && rx_mid && rx_cnt_reg == 4'h2;
wire rd_rxbuf = rd_i && addr_i == `ASU_OFF_RXBUF;
always @(posedge core_clk_i)
begin
   if (srst_i)
   begin
      mode_reg <= `ASU_RST_MODE;
      control0_reg <= `ASU_RST_CTRL0;
      control1_reg <= `ASU_RST_CTRL1;
      shared_serial_ctrl <= 8'h00;
      baud_divider <= `ASU_RST_BAUD;
      tx_buffer <= 9'h000;
      rx_buffer <= 9'h000;
      ovr_reg <= 1'b0;
      frm_reg <= 1'b0;
      par_reg <= 1'b0;
      rx_full_reg <= 1'b0;
      tx_be_reg <= 1'b1;
      tx_empty_reg <= 1'b1;
      started_reg <= 1'b0;
      ext_d_reg <= 1'b0;
      div_cnt_reg <= 8'h00;
      tx_sub_reg <= 4'h0;
      rx_sub_reg <= 4'h0;
      tx_st_reg <= ST_IDLE;
      rx_st_reg <= ST_IDLE;
      tx_sh_reg <= 13'h1fff;
      tx_cnt_reg <= 4'h0;
      rx_sh_reg <= 13'h0000;
      rx_cnt_reg <= 4'h0;
      rx_len_reg <= 4'h0;
      rxs_d_reg <= 1'b1;
      rdata_o <= 16'h0000;
      txd_o <= 1'b1;
      txd_oe_o <= 1'b1;
      rts_n_o <= 1'b1;
      rts_n_oe_o <= 1'b0;
      flow_pin_is_port_o <= 1'b0;
      clk_pin_is_port_o <= 1'b1;
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
   end
   else
   begin
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
      ext_d_reg <= ext_clock_pin_i;
      rxs_d_reg <= rx_pin;
      // Baud divider reloads with n so the 16x tick period is n+1 source ticks
      if (!ena)
         div_cnt_reg <= baud_divider;
      else if (src_tick)
         div_cnt_reg <= (div_cnt_reg == 8'h00) ? baud_divider : div_cnt_reg - 8'h01;
      // Register writes
      if (wr_i)
      begin
         case (addr_i)
            `ASU_OFF_TXBUF:
            begin
               tx_buffer <= wdata_i[8:0];
               tx_be_reg <= 1'b0;
            end
            `ASU_OFF_BAUD: baud_divider <= wdata_i[7:0];
            `ASU_OFF_MODE: mode_reg <= wdata_i[7:0];
            `ASU_OFF_CTRL0:
            begin
               control0_reg[2:0] <= wdata_i[2:0];
               control0_reg[7:4] <= wdata_i[7:4];
            end
            `ASU_OFF_CTRL1:
            begin
               control1_reg[0] <= wdata_i[0];
               control1_reg[2] <= wdata_i[2];
               control1_reg[7:4] <= wdata_i[7:4];
            end
            `ASU_OFF_SHARED: shared_serial_ctrl <= wdata_i[7:0];
            default: ;
         endcase
      end
      // Register reads, data one cycle later
      rdata_o <= 16'h0000;
      if (rd_i)
      begin
         case (addr_i)
            `ASU_OFF_TXBUF: rdata_o <= {7'h00, tx_buffer};
            `ASU_OFF_RXBUF: rdata_o <= {ovr_reg | frm_reg | par_reg, par_reg, frm_reg, ovr_reg,
               3'h0, rx_buffer};
            `ASU_OFF_BAUD: rdata_o <= {8'h00, baud_divider};
            `ASU_OFF_MODE: rdata_o <= {8'h00, mode_reg};
            `ASU_OFF_CTRL0: rdata_o <= {8'h00, control0_reg[7:4], tx_empty_reg, control0_reg[2:0]};
            `ASU_OFF_CTRL1: rdata_o <= {8'h00, control1_reg[7:4], rx_full_reg, control1_reg[2],
               tx_be_reg, control1_reg[0]};
            `ASU_OFF_SHARED: rdata_o <= {8'h00, shared_serial_ctrl};
            default: rdata_o <= 16'h0000;
         endcase
      end
      // Reading the receive buffer clears full and overrun; a same-cycle set of full wins below, overrun is not set during a read
      if (rd_rxbuf)
      begin
         rx_full_reg <= 1'b0;
         ovr_reg <= 1'b0;
      end
      // Transmitter
      if (!ena)
      begin
         tx_st_reg <= ST_IDLE;
         tx_be_reg <= 1'b1;
         tx_empty_reg <= 1'b1;
         started_reg <= 1'b0;
         tx_sh_reg <= 13'h1fff;
      end
      else if (tx_go)
      begin
         // Shift word: start low, data, parity, stops high
         // Parity sits right after the last character bit; in 9-bit mode that bit is sent from tx_buffer bit 8
         tx_sh_reg <= {4'hf, tx_msk} << 1 | (pen ? {12'h000, tx_par} << (4'h1 + clen) : 13'h0000)
            | ({13{1'b1}} << (4'h1 + clen + {3'h0, pen}));
         tx_cnt_reg <= tx_total - 4'h1;
         tx_st_reg <= ST_BITS;
         tx_sub_reg <= 4'h0;
         // A buffer write in the load cycle keeps its data-present state
         if (!(wr_i && addr_i == `ASU_OFF_TXBUF))
            tx_be_reg <= 1'b1;
         tx_empty_reg <= 1'b0;
         started_reg <= 1'b1;
         if (!control1_reg[`ASU_C1_IRQSRC])
            tx_irq_o <= 1'b1;
      end
      else if (tx_st_reg == ST_BITS && tick)
      begin
         tx_sub_reg <= tx_sub_reg + 4'h1;
         if (tx_sub_reg == 4'hf)
         begin
            tx_sh_reg <= {1'b1, tx_sh_reg[12:1]};
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
            if (tx_cnt_reg == 4'h0)
            begin
               tx_st_reg <= ST_IDLE;
               tx_empty_reg <= 1'b1;
               if (control1_reg[`ASU_C1_IRQSRC])
                  tx_irq_o <= 1'b1;
            end
         end
      end
      // Receiver; disabling reception empties the buffer state
      if (!ena || !control1_reg[`ASU_C1_RXON])
      begin
         rx_st_reg <= ST_IDLE;
         if (!control1_reg[`ASU_C1_RXON])
            rx_full_reg <= 1'b0;
      end
      else
      begin
         case (rx_st_reg)
            ST_IDLE:
               if (rxs_d_reg && !rx_pin)
               begin
                  rx_st_reg <= ST_START;
                  rx_sub_reg <= 4'h0;
               end
            ST_START:
               if (rx_mid)
               begin
                  if (rx_pin)
                     rx_st_reg <= ST_IDLE;
                  else
                  begin
                     rx_st_reg <= ST_BITS;
                     rx_cnt_reg <= tx_total - 4'h1;
                     rx_len_reg <= tx_total - 4'h1;
                  end
                  rx_sub_reg <= rx_sub_reg + 4'h1;
               end
               else if (tick)
                  rx_sub_reg <= rx_sub_reg + 4'h1;
            ST_BITS:
               if (tick)
               begin
                  rx_sub_reg <= rx_sub_reg + 4'h1;
                  if (rx_mid)
                  begin
                     rx_sh_reg <= rx_w;
                     rx_cnt_reg <= rx_cnt_reg - 4'h1;
                  end
                  if (rx_prelast && rx_full_reg && !rd_rxbuf)
                     ovr_reg <= 1'b1;
                  if (rx_done)
                  begin
                     rx_st_reg <= ST_IDLE;
                     if (!ovr_reg && !(rx_full_reg && !rd_rxbuf))
                     begin
                        rx_buffer <= rx_ord ^ ({9{inv}} & ((9'h001 << clen) - 9'h001));
                        frm_reg <= !(rx_s1 && rx_s2);
                        par_reg <= pen && ((^rx_raw) ^ rx_prb ^ podd);
                        rx_full_reg <= 1'b1;
                        rx_irq_o <= 1'b1;
                     end
                  end
               end
            default: rx_st_reg <= ST_IDLE;
         endcase
      end
      // Pins
      txd_o <= (started_reg ? tx_sh_reg[0] : 1'b1) ^ pol;
      txd_oe_o <= !(control0_reg[`ASU_C0_OPENDRN] && ((started_reg ? tx_sh_reg[0] : 1'b1) ^ pol));
      flow_pin_is_port_o <= !flow_on;
      rts_n_oe_o <= flow_on && control0_reg[`ASU_C0_FLOWDIR];
      rts_n_o <= !(control1_reg[`ASU_C1_RXON] && !rx_full_reg);
      clk_pin_is_port_o <= !ext_sel;
   end
end
endmodule // asu_uart

// ==== src/asu_regs.vh ====
// Register offsets, field positions, reset values and encodings for the async serial block
`ifndef ASU_REGS_VH
`define ASU_REGS_VH
`define ASU_ADDR_W 4
`define ASU_OFF_TXBUF 4'h0
`define ASU_OFF_RXBUF 4'h1
`define ASU_OFF_BAUD 4'h2
`define ASU_OFF_MODE 4'h3
`define ASU_OFF_CTRL0 4'h4
`define ASU_OFF_CTRL1 4'h5
`define ASU_OFF_SHARED 4'h6
// mode_reg fields
`define ASU_MODE_SMD_LO 0
`define ASU_MODE_SMD_HI 2
`define ASU_MODE_CKSRC 3
`define ASU_MODE_STOP2 4
`define ASU_MODE_PODD 5
`define ASU_MODE_PEN 6
`define ASU_MODE_PIN_POLARITY_INVERT 7
`define ASU_SMD_OFF 3'h0
`define ASU_SMD_7BIT 3'h4
`define ASU_SMD_8BIT 3'h5
`define ASU_SMD_9BIT 3'h6
// control0_reg fields
`define ASU_C0_PSC_LO 0
`define ASU_C0_PSC_HI 1
`define ASU_C0_FLOWDIR 2
`define ASU_C0_TXEMPTY 3
`define ASU_C0_FLOWDIS 4
`define ASU_C0_OPENDRN 5
`define ASU_C0_MSBFIRST 7
// control1_reg fields
`define ASU_C1_TXON 0
`define ASU_C1_TXBE 1
`define ASU_C1_RXON 2
`define ASU_C1_RXFULL 3
`define ASU_C1_IRQSRC 4
`define ASU_C1_LOGINV 6
// shared_serial_ctrl fields
`define ASU_SH_SPLIT 6
// rx_buffer status fields
`define ASU_RB_OVR 12
`define ASU_RB_FRM 13
`define ASU_RB_PAR 14
`define ASU_RB_SUM 15
// Reset values
`define ASU_RST_MODE 8'h00
`define ASU_RST_CTRL0 8'h18
`define ASU_RST_CTRL1 8'h02
`define ASU_RST_BAUD 8'h00
// Timing
`define ASU_OVERSAMPLE 5'h10
`define ASU_MID_TICK 4'h7
`endif

// ==== tb/asu_uart_sva.sv ====
// Port checker for the async serial block
`timescale 1ns/1ps
`include "asu_regs.vh"
module asu_uart_sva
(
   // Clock, reset and register port
   input wire core_clk_i,
   input wire srst_i,
   input wire [`ASU_ADDR_W-1:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   // Pins and requests
   input wire txd_o,
   input wire txd_oe_o,
   input wire rts_n_o,
   input wire rts_n_oe_o,
   input wire clk_pin_is_port_o,
   input wire tx_irq_o,
   input wire rx_irq_o
);
   // Shadows of irq source, rx on, tx on and pin polarity
   reg [2:0] c1_reg;
   reg pol_reg;
   always @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         c1_reg <= 3'h0;
         pol_reg <= 1'b0;
      end
      else if (wr_i && addr_i == `ASU_OFF_CTRL1)
         c1_reg <= {wdata_i[4], wdata_i[2], wdata_i[0]};
      else if (wr_i && addr_i == `ASU_OFF_MODE)
         pol_reg <= wdata_i[7];
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_mode_wr;
      wr_i && addr_i == `ASU_OFF_MODE;
   endsequence
   sequence s_load_req;
      tx_irq_o && !c1_reg[2] && !pol_reg;
   endsequence
   a_reset_idle_out: assert property ($fell(srst_i) |-> txd_o && txd_oe_o && rts_n_o && !rts_n_oe_o)
      else $error("outputs not idle after reset");
   a_tx_req_pulse: assert property (tx_irq_o |=> !tx_irq_o)
      else $error("tx request longer than one cycle");
   a_rx_req_pulse: assert property (rx_irq_o |=> !rx_irq_o)
      else $error("rx request longer than one cycle");
   a_clk_pin_role: assert property (s_mode_wr |-> ##2 clk_pin_is_port_o == !$past(wdata_i[3], 2))
      else $error("clock pin role does not follow clock source");
   a_load_then_start: assert property (s_load_req |-> ##[0:2] !txd_o)
      else $error("no start bit after buffer load");
   a_rts_full_high: assert property (rx_irq_o |-> ##[0:2] rts_n_o)
      else $error("rts low with full buffer");
   a_tx_needs_on: assert property (tx_irq_o |-> c1_reg[0])
      else $error("transmit while disabled");
   a_rx_needs_on: assert property (rx_irq_o |-> c1_reg[1])
      else $error("receive while disabled");
endmodule // asu_uart_sva
bind asu_uart asu_uart_sva chk_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .rts_n_o(rts_n_o), .rts_n_oe_o(rts_n_oe_o),
   .clk_pin_is_port_o(clk_pin_is_port_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));

// ==== tb/asu_line_model.sv ====
// Remote serial transceiver on the line
`timescale 1ns/1ps
module asu_line_model
(
   // Clock
   input wire core_clk_i,
   // Line
   input wire txd_i,
   output reg rxd_o
);
   // Bit time in core cycles, divider 1 at div1 source
   int bper = 32;
   // Line rests high like a pulled-up wire
   initial rxd_o = 1'b1;
   task automatic put(input logic b);
      rxd_o <= b;
      repeat (bper) @(posedge core_clk_i);
   endtask
   task automatic send(input logic [8:0] d, input int nb, input logic pen, input logic pb, input logic stopv);
      int i;
      @(posedge core_clk_i);
      put(1'b0);
      for (i = 0; i < nb; i++)
         put(d[i]);
      if (pen)
         put(pb);
      put(stopv);
      rxd_o <= 1'b1;
   endtask
   // Samples mid-bit, so a wrong bit rate shows as wrong data
   task automatic recv(input int nb, output logic [8:0] d, output logic pb, output logic stopv);
      int i;
      d = 9'h000;
      @(negedge txd_i);
      repeat (bper / 2) @(posedge core_clk_i);
      for (i = 0; i < nb; i++)
      begin
         repeat (bper) @(posedge core_clk_i);
         d[i] = txd_i;
      end
      repeat (bper) @(posedge core_clk_i);
      pb = txd_i;
      repeat (bper) @(posedge core_clk_i);
      stopv = txd_i;
   endtask
endmodule // asu_line_model

// ==== tb/asu_uart_tb.sv ====
// Self-checking bench for the async serial block
`timescale 1ns/1ps
`include "asu_regs.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module asu_uart_tb;
   reg core_clk_i = 1'b0;
   reg srst_i = 1'b1;
   reg [3:0] addr_i = 4'h0;
   reg [15:0] wdata_i = 16'h0000;
   reg wr_i = 1'b0;
   reg rd_i = 1'b0;
   reg cts_n_i = 1'b1;
   reg ext_clk = 1'b0;
   wire [15:0] rdata_o;
   wire rxd, txd, txd_oe, rts_n, rts_oe, flow_port, clk_port, tx_irq, rx_irq;
   int n_mismatch = 0;
   int comparisons = 0;
   int n_tx = 0;
   int n_rx = 0;
   always #2 core_clk_i = ~core_clk_i;
   // External transfer clock at half the core rate
   always @(posedge core_clk_i)
      ext_clk <= ~ext_clk;
   always @(posedge core_clk_i)
   begin
      if (tx_irq === 1'b1)
         n_tx <= n_tx + 1;
      if (rx_irq === 1'b1)
         n_rx <= n_rx + 1;
   end
   asu_uart dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .presc_tick_i(4'hF), .ext_clock_pin_i(ext_clk), .rxd_i(rxd), .txd_o(txd),
      .txd_oe_o(txd_oe), .cts_n_i(cts_n_i), .shared_port_pin_i(1'b1), .rts_n_o(rts_n), .rts_n_oe_o(rts_oe),
      .flow_pin_is_port_o(flow_port), .clk_pin_is_port_o(clk_port), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
   asu_line_model line_u (.core_clk_i(core_clk_i), .txd_i(txd), .rxd_o(rxd));
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(posedge core_clk_i);
      d = rdata_o;
   endtask
   task automatic t_reset;
      logic [15:0] v;
      `CHK("txd idle", 2'b11, {txd, txd_oe})
      `CHK("rts pin", 2'b01, {rts_oe, rts_n})
      rd(`ASU_OFF_CTRL0, v);
      `CHK("ctrl0 reset", 16'h0018, v)
      rd(`ASU_OFF_CTRL1, v);
      `CHK("ctrl1 reset", 16'h0002, v)
      rd(4'hF, v);
      `CHK("unmapped read", 16'h0000, v)
      wr(`ASU_OFF_MODE, 16'h000D);
      repeat (3) @(posedge core_clk_i);
      `CHK("clock pin port", 1'b0, clk_port)
      `CHK("flow pin port", 1'b1, flow_port)
      $display("test reset done");
   endtask
   task automatic t_tx;
      logic [8:0] d;
      logic [7:0] e;
      logic pb, sv;
      int k;
      wr(`ASU_OFF_BAUD, 16'h0001);
      wr(`ASU_OFF_CTRL0, 16'h0010);
      wr(`ASU_OFF_MODE, 16'h0045);
      wr(`ASU_OFF_CTRL1, 16'h0005);
      for (k = 0; k < 2; k++)
      begin
         e = k ? 8'h36 : 8'hA5;
         if (k == 1)
            wr(`ASU_OFF_CTRL1, 16'h0015);
         fork
            line_u.recv(8, d, pb, sv);
            wr(`ASU_OFF_TXBUF, {8'h00, e});
         join
         `CHK("request timing", 1, n_tx)
         `CHK("tx char", e, d[7:0])
         `CHK("tx parity", ^e, pb)
         `CHK("tx stop", 1'b1, sv)
         repeat (40) @(posedge core_clk_i);
         `CHK("tx requests", k + 1, n_tx)
      end
      $display("test transmit done");
   endtask
   task automatic t_rx;
      logic [15:0] v;
      int k;
      for (k = 0; k < 3; k++)
      begin
         wr(`ASU_OFF_MODE, 16'h0004 + k);
         line_u.send(9'h1A5, 7 + k, 1'b0, 1'b0, 1'b1);
         rd(`ASU_OFF_RXBUF, v);
         `CHK("rx char", 16'h01A5 & ((16'h0001 << (7 + k)) - 16'h0001), v)
      end
      `CHK("rx requests", 3, n_rx)
      wr(`ASU_OFF_MODE, 16'h0045);
      line_u.send(9'h03C, 8, 1'b1, 1'b1, 1'b1);
      rd(`ASU_OFF_RXBUF, v);
      `CHK("parity fault", 16'hC03C, v)
      line_u.send(9'h03C, 8, 1'b1, 1'b0, 1'b0);
      rd(`ASU_OFF_RXBUF, v);
      `CHK("framing fault", 16'hA03C, v)
      line_u.send(9'h05A, 8, 1'b1, 1'b0, 1'b1);
      rd(`ASU_OFF_RXBUF, v);
      `CHK("flags renewed", 16'h005A, v)
      k = n_rx;
      line_u.send(9'h011, 8, 1'b1, 1'b0, 1'b1);
      line_u.send(9'h022, 8, 1'b1, 1'b0, 1'b1);
      rd(`ASU_OFF_RXBUF, v);
      `CHK("overrun flags", 16'h9000, v & 16'hF000)
      `CHK("request held", k + 1, n_rx)
      wr(`ASU_OFF_CTRL1, 16'h0011);
      wr(`ASU_OFF_CTRL1, 16'h0015);
      rd(`ASU_OFF_CTRL1, v);
      `CHK("rx buffer cleared", 16'h0017, v)
      $display("test receive done");
   endtask
   task automatic t_cts;
      logic [8:0] d;
      logic pb, sv;
      int k;
      k = n_tx;
      wr(`ASU_OFF_CTRL0, 16'h0000);
      wr(`ASU_OFF_TXBUF, 16'h005A);
      repeat (200) @(posedge core_clk_i);
      `CHK("held by cts", 2'b11, {txd, k == n_tx})
      fork
         line_u.recv(8, d, pb, sv);
         cts_n_i <= 1'b0;
      join
      `CHK("cts char", 8'h5A, d[7:0])
      wr(`ASU_OFF_CTRL0, 16'h0004);
      repeat (3) @(posedge core_clk_i);
      `CHK("rts ready", 2'b10, {rts_oe, rts_n})
      $display("test flow control done");
   endtask
   task automatic t_ext;
      logic [8:0] d;
      logic pb, sv;
      wr(`ASU_OFF_BAUD, 16'h0000);
      wr(`ASU_OFF_CTRL0, 16'h0090);
      wr(`ASU_OFF_MODE, 16'h004D);
      fork
         line_u.recv(8, d, pb, sv);
         wr(`ASU_OFF_TXBUF, 16'h0013);
      join
      `CHK("ext clock char", 8'hC8, d[7:0])
      `CHK("msb first parity", 1'b1, pb)
      `CHK("ext clock stop", 1'b1, sv)
      $display("test external clock done");
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge core_clk_i);
      srst_i <= 1'b0;
      @(posedge core_clk_i);
      t_reset;
      t_tx;
      t_rx;
      t_cts;
      t_ext;
      report_and_stop;
   end
   // Whole run needs about 4500 cycles
   initial
   begin
      repeat (30000) @(posedge core_clk_i);
      n_mismatch++;
      report_and_stop;
   end
endmodule // asu_uart_tb
